// >>> core/intr_route_cfg.svh
`ifndef INTR_ROUTE_CFG_SVH
`define INTR_ROUTE_CFG_SVH
`define SRC_FIXED 2'h0
`define SRC_DMA   2'h1
`define SRC_LOGIC 2'h2
`define PC_W      16
`endif

// >>> core/intr_route_pkg.sv
package intr_route_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_PUSH,
    ST_JUMP,
    ST_POP
  } seq_state_t;
  typedef struct packed {
    logic        take;
    logic [4:0]  vector;
    logic [15:0] target_pc;
  } entry_t;
endpackage

// >>> core/interrupt_vector_routing.sv
`timescale 1ns/1ns
`include "intr_route_cfg.svh"
module interrupt_vector_routing #(
  parameter int NVEC  = 32,
  parameter int NFIX  = 32,
  parameter int NDMA  = 16,
  parameter int NLOG  = 64,
  parameter int PRI_W = 3
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [NFIX-1:0]          fixed_req,
  input  wire logic [2*NDMA-1:0]        dma_chan_req,
  input  wire logic [NLOG-1:0]          logic_array_sig,
  input  wire logic [NVEC-1:0][1:0]     vec_src_type,
  input  wire logic [NVEC-1:0][5:0]     vec_src_index,
  input  wire logic [NVEC-1:0][PRI_W-1:0] vec_priority,
  input  wire logic [NVEC-1:0]          vec_disable,
  input  wire logic [NVEC-1:0][15:0]   vec_address,
  input  wire logic [NDMA-1:0][5:0]     dma_log_index,
  input  wire logic [NDMA-1:0]          dma_log_enable,
  input  wire logic                     instr_done,
  input  wire logic                     return_from_interrupt_instruction_exec,
  input  wire logic [15:0]              next_pc,
  input  wire logic [15:0]              stack_pc,
  output logic                          push_pc,
  output logic                          pop_pc,
  output logic [15:0]                   push_value,
  output logic                          load_pc,
  output logic [15:0]                   load_value,
  output logic [4:0]                    active_vector,
  output logic                          in_handler,
  output logic [NDMA-1:0]               dma_logic_req
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    intr_route_pkg::seq_state_t st;
    intr_route_pkg::entry_t     ent;
    logic                       push;
    logic                       pop;
    logic [15:0]                push_v;
    logic                       load;
    logic [15:0]                load_v;
    logic                       busy;
    logic [NDMA-1:0]            dreq;
  } state_t;
  state_t s_q;
  state_t s_d;
  logic [NVEC-1:0] vreq;
  intr_route_pkg::entry_t win;
  logic [PRI_W-1:0] best_pri;
  // ----------------------------------------
  // source routing
  // ----------------------------------------
  // inputs come from logic on this clock, so no synchroniser
  always_comb begin
    for (int v = 0; v < NVEC; v++) begin
      case (vec_src_type[v])
        `SRC_FIXED: vreq[v] = fixed_req[vec_src_index[v][4:0]];
        `SRC_DMA:   vreq[v] = dma_chan_req[vec_src_index[v][4:0]];
        `SRC_LOGIC: vreq[v] = logic_array_sig[vec_src_index[v]];
        default:    vreq[v] = 1'b0;
      endcase
    end
  end
  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  always_comb begin
    win = '0;
    best_pri = '0;
    // descending scan so lower number overwrites on ties
    for (int v = NVEC - 1; v >= 0; v--) begin
      if (vreq[v] && !vec_disable[v]) begin
        if (!win.take || vec_priority[v] <= best_pri) begin
          win.take = 1'b1;
          win.vector = 5'(v);
          win.target_pc = vec_address[v];
          best_pri = vec_priority[v];
        end
      end
    end
  end
  // ----------------------------------------
  // entry and return sequence
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    s_d.pop = 1'b0;
    s_d.load = 1'b0;
    for (int c = 0; c < NDMA; c++) begin
      s_d.dreq[c] = dma_log_enable[c] && logic_array_sig[dma_log_index[c]];
    end
    case (s_q.st)
      intr_route_pkg::ST_RUN: begin
        if (s_q.busy && return_from_interrupt_instruction_exec) begin
          s_d.st = intr_route_pkg::ST_POP;
        end else if (!s_q.busy && win.take && instr_done) begin
          s_d.ent = win;
          s_d.push = 1'b1;
          s_d.push_v = next_pc;
          s_d.st = intr_route_pkg::ST_PUSH;
        end
      end
      intr_route_pkg::ST_PUSH: begin
        s_d.load = 1'b1;
        s_d.load_v = s_q.ent.target_pc;
        s_d.busy = 1'b1;
        s_d.st = intr_route_pkg::ST_RUN;
      end
      intr_route_pkg::ST_POP: begin
        s_d.pop = 1'b1;
        s_d.load = 1'b1;
        s_d.load_v = stack_pc;
        s_d.busy = 1'b0;
        s_d.st = intr_route_pkg::ST_RUN;
      end
      default: s_d.st = intr_route_pkg::ST_RUN;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign push_pc = s_q.push;
  assign pop_pc = s_q.pop;
  assign push_value = s_q.push_v;
  assign load_pc = s_q.load;
  assign load_value = s_q.load_v;
  assign active_vector = s_q.ent.vector;
  assign in_handler = s_q.busy;
  assign dma_logic_req = s_q.dreq;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // push after done
  property p_push_cause;
    @(posedge clk) disable iff (!rst_n) $rose(push_pc) |-> $past(instr_done) && $past(win.take);
  endproperty
  a_push_cause: assert property (p_push_cause) else $error("push without finished instruction");
  property p_jump;
    @(posedge clk) disable iff (!rst_n) push_pc |=> load_pc && load_value == $past(win.target_pc, 2);
  endproperty
  a_jump: assert property (p_jump) else $error("no jump to vector address");
  property p_pop;
    @(posedge clk) disable iff (!rst_n) (in_handler && return_from_interrupt_instruction_exec && !push_pc && !load_pc) |-> ##2 (pop_pc && load_pc);
  endproperty
  a_pop: assert property (p_pop) else $error("return did not pop");
  property p_tie;
    @(posedge clk) disable iff (!rst_n) push_pc |-> !($past(vreq[0]) && !$past(vec_disable[0])) || active_vector == 5'h0
      || $past(vec_priority[0]) > $past(vec_priority[win.vector]);
  endproperty
  a_tie: assert property (p_tie) else $error("vector zero lost a tie");
  property p_disable;
    @(posedge clk) disable iff (!rst_n) push_pc |-> !$past(vec_disable[win.vector]);
  endproperty
  a_disable: assert property (p_disable) else $error("disabled vector taken");
  property p_dma_log;
    @(posedge clk) disable iff (!rst_n) (dma_log_enable[0] && logic_array_sig[dma_log_index[0]]) |=> dma_logic_req[0];
  endproperty
  a_dma_log: assert property (p_dma_log) else $error("logic signal lost dma request");
  property p_route;
    @(posedge clk) disable iff (!rst_n) (vec_src_type[0] == `SRC_LOGIC) |-> vreq[0] == logic_array_sig[vec_src_index[0]];
  endproperty
  a_route: assert property (p_route) else $error("logic source misrouted");
  property p_dma_src;
    @(posedge clk) disable iff (!rst_n) (vec_src_type[0] == `SRC_DMA) |-> vreq[0] == dma_chan_req[vec_src_index[0][4:0]];
  endproperty
  a_dma_src: assert property (p_dma_src) else $error("dma source misrouted");
  property p_push_value;
    @(posedge clk) disable iff (!rst_n) push_pc |-> push_value == $past(next_pc);
  endproperty
  a_push_value: assert property (p_push_value) else $error("pushed wrong return address");
  property p_no_nest;
    @(posedge clk) disable iff (!rst_n) in_handler |-> !push_pc;
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("entry taken inside a handler");
  property p_load_pulse;
    @(posedge clk) disable iff (!rst_n) load_pc |=> !load_pc;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load strobe longer than one cycle");
  property p_enter_flag;
    @(posedge clk) disable iff (!rst_n) (load_pc && !pop_pc) |-> in_handler;
  endproperty
  a_enter_flag: assert property (p_enter_flag) else $error("jump without handler flag");
  property p_pop_value;
    @(posedge clk) disable iff (!rst_n) pop_pc |-> load_pc && !in_handler && load_value == $past(stack_pc);
  endproperty
  a_pop_value: assert property (p_pop_value) else $error("return loaded wrong address");
  property p_dma_idle;
    @(posedge clk) disable iff (!rst_n) !dma_log_enable[0] |=> !dma_logic_req[0];
  endproperty
  a_dma_idle: assert property (p_dma_idle) else $error("dma request from disabled route");
endmodule

// >>> bench/core_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// core side: counter and one-deep stack
// ----------------------------------------
module core_model (
  input  wire logic        clk,
  input  wire logic        push_pc,
  input  wire logic [15:0] push_value,
  input  wire logic        load_pc,
  input  wire logic [15:0] load_value,
  output logic      [15:0] next_pc,
  output logic      [15:0] stack_pc
);
  // one level is enough, the block never nests
  initial stack_pc = 16'h0000;
  initial next_pc = 16'h0100;
  always @(posedge clk) begin
    if (push_pc) stack_pc <= push_value;
    if (load_pc) next_pc <= load_value + 16'h0001;
  end
endmodule

// >>> bench/interrupt_vector_routing_test.sv
`timescale 1ns/1ns
// ----------------------------------------
// bench
// ----------------------------------------
module interrupt_vector_routing_test;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [31:0]            fixed_req = 32'h0;
  logic [31:0]            dma_chan_req = 32'h0;
  logic [63:0]            logic_array_sig = 64'h0;
  logic [31:0][1:0]       vec_src_type;
  logic [31:0][5:0]       vec_src_index;
  logic [31:0][2:0]       vec_priority;
  logic [31:0]            vec_disable = 32'h0;
  logic [31:0][15:0]      vec_address;
  logic [15:0][5:0]       dma_log_index = '0;
  logic [15:0]            dma_log_enable = 16'h0;
  logic                   instr_done = 1'b0;
  logic                   return_from_interrupt_instruction_exec = 1'b0;
  logic                   push_pc, pop_pc, load_pc, in_handler;
  logic [15:0]            push_value, load_value, next_pc, stack_pc, dma_logic_req;
  logic [4:0]             active_vector;
  logic [15:0]            exp_pc = 16'h0100;
  logic [15:0]            saved;
  int                     miscompares = 0;
  int                     compares = 0;

  interrupt_vector_routing u_interrupt_vector_routing (.clk, .rst_n, .fixed_req, .dma_chan_req,
    .logic_array_sig, .vec_src_type, .vec_src_index, .vec_priority, .vec_disable, .vec_address,
    .dma_log_index, .dma_log_enable, .instr_done, .return_from_interrupt_instruction_exec, .next_pc, .stack_pc, .push_pc,
    .pop_pc, .push_value, .load_pc, .load_value, .active_vector, .in_handler, .dma_logic_req);
  core_model u_core_model (.clk, .push_pc, .push_value, .load_pc, .load_value, .next_pc, .stack_pc);

  initial forever #5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input logic rt);
    @(negedge clk);
    instr_done = !rt;
    return_from_interrupt_instruction_exec = rt;
    @(negedge clk);
    instr_done = 1'b0;
    return_from_interrupt_instruction_exec = 1'b0;
  endtask

  task automatic entry(input logic [4:0] v);
    step(1'b0);
    chk(16'(push_pc), 16'h0001);
    chk(push_value, exp_pc);
    saved = exp_pc;
    @(negedge clk);
    chk(16'(load_pc), 16'h0001);
    chk(load_value, 16'h1000 + 16'(v));
    chk(16'(active_vector), 16'(v));
    chk(16'(in_handler), 16'h0001);
    exp_pc = 16'h1001 + 16'(v);
    $display("entry to vector %0d checked", v);
  endtask

  task automatic leave();
    step(1'b1);
    @(negedge clk);
    chk(16'(pop_pc & load_pc & !in_handler), 16'h0001);
    chk(load_value, saved);
    exp_pc = saved + 16'h0001;
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic test_fixed();
    vec_src_type[3] = 2'h0;
    vec_src_index[3] = 6'h04;
    fixed_req[4] = 1'b1;
    entry(5'h03);
    fixed_req[4] = 1'b0;
    leave();
    vec_src_type[3] = 2'h3;
    $display("fixed source test done");
  endtask

  // tie: logic signal on vector 0 and fixed line 4 on 5, equal priority
  task automatic test_tie();
    vec_src_type[0] = 2'h2;
    vec_src_index[0] = 6'h0A;
    vec_src_type[5] = 2'h0;
    vec_src_index[5] = 6'h04;
    logic_array_sig[10] = 1'b1;
    fixed_req[4] = 1'b1;
    entry(5'h00);
    logic_array_sig[10] = 1'b0;
    leave();
    entry(5'h05);
    fixed_req[4] = 1'b0;
    leave();
    $display("tie test done");
  endtask

  // second line of dma channel 2 on two vectors, logic signal 20 raising dma 0
  task automatic test_dma();
    vec_src_type[7] = 2'h1;
    vec_src_index[7] = 6'h05;
    vec_src_type[0] = 2'h1;
    vec_src_index[0] = 6'h05;
    vec_priority[0] = 3'h6;
    dma_chan_req[5] = 1'b1;
    dma_log_index[0] = 6'h14;
    dma_log_enable[0] = 1'b1;
    logic_array_sig[20] = 1'b1;
    entry(5'h07);
    chk(dma_logic_req, 16'h0001);
    logic_array_sig[20] = 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk(dma_logic_req, 16'h0000);
    dma_chan_req[5] = 1'b0;
    leave();
    $display("dma source test done");
  endtask

  // masked vector stays out although its line is held
  task automatic test_mask();
    vec_src_type[9] = 2'h0;
    vec_src_index[9] = 6'h09;
    vec_disable[9] = 1'b1;
    fixed_req[9] = 1'b1;
    step(1'b0);
    chk(16'({push_pc, load_pc, in_handler}), 16'h0000);
    @(negedge clk);
    chk(16'({push_pc, load_pc, in_handler}), 16'h0000);
    vec_disable[9] = 1'b0;
    entry(5'h09);
    fixed_req[9] = 1'b0;
    leave();
    $display("mask test done");
  endtask

  // watchdog: whole run is well under 2000 cycles
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end

  initial begin
    for (int v = 0; v < 32; v++) begin
      vec_src_type[v] = 2'h3;
      vec_src_index[v] = 6'h00;
      vec_priority[v] = 3'h4;
      vec_address[v] = 16'h1000 + 16'(v);
    end
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    test_fixed();
    test_tie();
    test_dma();
    test_mask();
    print_verdict();
  end
endmodule
